/* verilog/cah_pkg.sv */
// Functional notes
// - No handover while axis travels plus/minus
// - Start without axis: swap first, then move
// - Per-move: clearing start releases the axis
// - Reached holds during release; restart refused
// - Continuous request assigns axis, checkback confirms
// - Axis already held: skip swap, move now
// - Continuous: job ends, axis kept until released
// - Feed stop and channel stop/start interrupt
// - Delete distance or late start-clear cancels motion
// - Error flag loads one-byte error code
// - Clearing start after error clears code
// - Start refused while error flag set
// - Codes 2, 3, 10 for start faults
// - Codes 30 or 115: target not reached
// - Codes 125, 126, 127 for impossible moves
// - Codes 130-133 for software/working limits
// - Independent axis ignores channel stop/reset
// - Independent stop, continue, reset inputs obeyed
// - Program motion withholds independent mode, error
// - Independent error and reset-done checkbacks
// - Independent request pulse or reset aborts move
// - Accepted only in jog or automatic mode
// - Zero feed selects configured positioning velocity
// - Reached when axis in fine target range
package cah_pkg;
	localparam logic [3:0] ADR_CTRL = 4'h0;
	localparam logic [3:0] ADR_STAT = 4'h4;
	localparam logic [3:0] ADR_TARGET = 4'h8;
	localparam logic [3:0] ADR_FEED = 4'hC;
	localparam int CB_START = 0;
	localparam int CB_REQ = 1;
	localparam int CB_INCR = 2;
	localparam int CB_INCH = 3;
	localparam int CB_SHORT = 4;
	localparam int CB_IREQ = 5;
	localparam int CB_ISTOP = 6;
	localparam int CB_ICONT = 7;
	localparam int CB_IRST = 8;
	localparam int CTRL_W = 9;
	localparam logic [8:0] CTRL_RESET = 9'h000;
	localparam int SB_HOST = 0;
	localparam int SB_REACHED = 1;
	localparam int SB_ACTIVE = 2;
	localparam int SB_ERR = 3;
	localparam int SB_IMODE = 4;
	localparam int SB_IERR = 5;
	localparam int SB_IRACK = 6;
	localparam int SB_CODE = 8;
	localparam int SB_ICODE = 16;
	localparam int P_TRAV_P = 0;
	localparam int P_TRAV_M = 1;
	localparam int P_FSTOP = 2;
	localparam int P_CSTOP = 3;
	localparam int P_CSTART = 4;
	localparam int P_DELDTG = 5;
	localparam int P_FINE = 6;
	localparam int P_SERVO = 7;
	localparam int P_MODE = 8;
	localparam int P_PROG = 9;
	localparam int P_SWL_P = 10;
	localparam int P_SWL_M = 11;
	localparam int P_WAL_P = 12;
	localparam int P_WAL_M = 13;
	localparam int P_MISSED = 14;
	localparam int P_SP_IMP = 15;
	localparam int P_ABSM_IMP = 16;
	localparam int P_ABSP_IMP = 17;
	localparam int NPIN = 18;
	localparam logic [7:0] EC_NONE = 8'h00;
	localparam logic [7:0] EC_NOSTART = 8'h02;
	localparam logic [7:0] EC_SERVO = 8'h03;
	localparam logic [7:0] EC_SP_INCR = 8'h0A;
	localparam logic [7:0] EC_MISSED = 8'h1E;
	localparam logic [7:0] EC_ABORTED = 8'h73;
	localparam logic [7:0] EC_SP_IMP = 8'h7D;
	localparam logic [7:0] EC_ABSM = 8'h7E;
	localparam logic [7:0] EC_ABSP = 8'h7F;
	localparam logic [7:0] EC_SWL_P = 8'h82;
	localparam logic [7:0] EC_SWL_M = 8'h83;
	localparam logic [7:0] EC_WAL_P = 8'h84;
	localparam logic [7:0] EC_WAL_M = 8'h85;
	localparam logic [15:0] IEC_PROG = 16'h65D8;
	localparam int CLK_MHZ = 100;
	localparam int SWAP_TIME_NS = 40;
	localparam int SWAP_CYC = (SWAP_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam logic [31:0] POS_VEL_RESET = 32'h0000_1000;
	typedef enum logic [2:0] {ST_IDLE, ST_SWAP, ST_MOVE, ST_DONE, ST_RELEASE, ST_ERR}
		cah_state_type;
endpackage

/* verilog/cah_axis_ctrl.sv */
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module cah_axis_ctrl #(
	parameter logic [31:0] POS_VEL = cah_pkg::POS_VEL_RESET
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Avalon-MM slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Module motion status, asynchronous to ref_clk
	input wire logic travel_plus,
	input wire logic travel_minus,
	input wire logic feed_stop,
	input wire logic chan_stop,
	input wire logic chan_start,
	input wire logic delete_dtg,
	input wire logic in_fine_range,
	input wire logic servo_enable,
	input wire logic mode_jog_auto,
	input wire logic prog_moving,
	input wire logic swl_plus,
	input wire logic swl_minus,
	input wire logic wal_plus,
	input wire logic wal_minus,
	input wire logic target_missed,
	input wire logic short_impossible,
	input wire logic absm_impossible,
	input wire logic absp_impossible,
	// Motion command to the axis
	output logic axis_swap_req,
	output logic move_run,
	output logic move_cancel,
	output logic move_incr,
	output logic move_inch,
	output logic [31:0] move_target,
	output logic [31:0] move_feed
);
	if (POS_VEL == 32'h0000_0000) begin : g_bad_vel
		$error("POS_VEL must be nonzero");
	end

	typedef struct packed {
		logic [cah_pkg::NPIN-1:0] pin_s1;
		logic [cah_pkg::NPIN-1:0] pin_s2;
		logic [cah_pkg::CTRL_W-1:0] ctrl;
		logic [31:0] target;
		logic [31:0] feed;
		logic wait_req;
		logic [31:0] rdata;
		cah_pkg::cah_state_type st;
		logic [3:0] cnt;
		logic host_axis;
		logic reached;
		logic err;
		logic [7:0] code;
		logic chan_halt;
		logic ind_halt;
		logic ever_req;
		logic imode;
		logic ierr;
		logic [15:0] icode;
		logic irack;
		logic ireq_seen;
		logic swap_req;
		logic run;
		logic cancel;
		logic [31:0] feed_out;
	} cah_regs_type;

	cah_regs_type r;
	cah_regs_type nxt_r;
	logic [cah_pkg::NPIN-1:0] pins;
	logic [cah_pkg::NPIN-1:0] p;
	logic [cah_pkg::CTRL_W-1:0] c;
	logic travel;

	assign pins = {absp_impossible, absm_impossible, short_impossible, target_missed, wal_minus,
		wal_plus, swl_minus, swl_plus, prog_moving, mode_jog_auto, servo_enable, in_fine_range,
		delete_dtg, chan_start, chan_stop, feed_stop, travel_minus, travel_plus};
	assign p = r.pin_s2;
	assign c = r.ctrl;
	assign travel = p[cah_pkg::P_TRAV_P] | p[cah_pkg::P_TRAV_M];

	// Start-time checks in priority order; zero means the move may begin
	function automatic logic [7:0] start_fault(input logic [cah_pkg::NPIN-1:0] pv,
		input logic [cah_pkg::CTRL_W-1:0] cv);
		logic [7:0] ec;
		ec = cah_pkg::EC_NONE;
		if (pv[cah_pkg::P_TRAV_P] | pv[cah_pkg::P_TRAV_M] | !pv[cah_pkg::P_MODE]) begin
			ec = cah_pkg::EC_NOSTART;
		end else if (!pv[cah_pkg::P_SERVO]) begin
			ec = cah_pkg::EC_SERVO;
		end else if (cv[cah_pkg::CB_SHORT] & cv[cah_pkg::CB_INCR]) begin
			ec = cah_pkg::EC_SP_INCR;
		end else if (pv[cah_pkg::P_SP_IMP]) begin
			ec = cah_pkg::EC_SP_IMP;
		end else if (pv[cah_pkg::P_ABSM_IMP]) begin
			ec = cah_pkg::EC_ABSM;
		end else if (pv[cah_pkg::P_ABSP_IMP]) begin
			ec = cah_pkg::EC_ABSP;
		end
		return ec;
	endfunction

	always_comb begin
		logic [7:0] sf;
		logic [7:0] mf;
		logic abort_ind;
		nxt_r = r;
		sf = start_fault(p, c);
		mf = cah_pkg::EC_NONE;
		abort_ind = 1'b0;
		nxt_r.pin_s1 = pins;
		nxt_r.pin_s2 = r.pin_s1;
		nxt_r.cancel = 1'b0;

		// Bus: answer one cycle after the request is seen, effect at the completing edge
		nxt_r.wait_req = !((avs_read | avs_write) & r.wait_req);
		if (avs_read & r.wait_req) begin
			unique case (avs_address)
				cah_pkg::ADR_CTRL: nxt_r.rdata = {23'h000000, r.ctrl};
				cah_pkg::ADR_STAT: nxt_r.rdata = {r.icode, r.code, 1'b0, r.irack, r.ierr,
					r.imode, r.err, r.run, r.reached, r.host_axis};
				cah_pkg::ADR_TARGET: nxt_r.rdata = r.target;
				cah_pkg::ADR_FEED: nxt_r.rdata = r.feed;
				default: nxt_r.rdata = 32'h0000_0000;
			endcase
		end
		if (avs_write & !r.wait_req) begin
			unique case (avs_address)
				cah_pkg::ADR_CTRL: nxt_r.ctrl = avs_writedata[cah_pkg::CTRL_W-1:0];
				cah_pkg::ADR_TARGET: nxt_r.target = avs_writedata;
				cah_pkg::ADR_FEED: nxt_r.feed = avs_writedata;
				default: ;
			endcase
		end

		// Channel stop latches until channel start; ignored for an independent axis
		if (p[cah_pkg::P_CSTART] | r.imode) begin
			nxt_r.chan_halt = 1'b0;
		end else if (p[cah_pkg::P_CSTOP]) begin
			nxt_r.chan_halt = 1'b1;
		end
		if (c[cah_pkg::CB_ICONT] | !r.imode) begin
			nxt_r.ind_halt = 1'b0;
		end else if (c[cah_pkg::CB_ISTOP]) begin
			nxt_r.ind_halt = 1'b1;
		end

		// Independent mode needs one axis request since reset
		if (c[cah_pkg::CB_REQ]) begin
			nxt_r.ever_req = 1'b1;
		end
		if (!c[cah_pkg::CB_IREQ]) begin
			nxt_r.imode = 1'b0;
			nxt_r.ierr = 1'b0;
			nxt_r.icode = 16'h0000;
		end else if (p[cah_pkg::P_PROG] & !r.imode) begin
			nxt_r.ierr = 1'b1;
			nxt_r.icode = cah_pkg::IEC_PROG;
		end else if (r.ever_req) begin
			nxt_r.imode = 1'b1;
		end
		nxt_r.irack = r.imode & c[cah_pkg::CB_IRST];
		nxt_r.ireq_seen = c[cah_pkg::CB_IREQ];

		if (r.st == cah_pkg::ST_MOVE) begin
			abort_ind = (r.ireq_seen & !c[cah_pkg::CB_IREQ])
				| (c[cah_pkg::CB_IREQ] & c[cah_pkg::CB_IRST]);
		end
		if (abort_ind) begin
			mf = cah_pkg::EC_ABORTED;
		end else if (p[cah_pkg::P_SWL_P]) begin
			mf = cah_pkg::EC_SWL_P;
		end else if (p[cah_pkg::P_SWL_M]) begin
			mf = cah_pkg::EC_SWL_M;
		end else if (p[cah_pkg::P_WAL_P]) begin
			mf = cah_pkg::EC_WAL_P;
		end else if (p[cah_pkg::P_WAL_M]) begin
			mf = cah_pkg::EC_WAL_M;
		end else if (p[cah_pkg::P_MISSED]) begin
			mf = cah_pkg::EC_MISSED;
		end

		unique case (r.st)
			cah_pkg::ST_IDLE: begin
				nxt_r.cnt = 4'h0;
				// Restart only once reached and error have both dropped
				if (c[cah_pkg::CB_START] & !r.reached & !r.err) begin
					if (sf != cah_pkg::EC_NONE) begin
						nxt_r.st = cah_pkg::ST_ERR;
						nxt_r.err = 1'b1;
						nxt_r.code = sf;
					end else if (r.host_axis) begin
						nxt_r.st = cah_pkg::ST_MOVE;
					end else begin
						nxt_r.st = cah_pkg::ST_SWAP;
						nxt_r.swap_req = 1'b1;
					end
				end else if (c[cah_pkg::CB_REQ] & !r.host_axis & !travel
					& p[cah_pkg::P_MODE]) begin
					nxt_r.st = cah_pkg::ST_SWAP;
					nxt_r.swap_req = 1'b1;
				end else if (!c[cah_pkg::CB_REQ] & r.host_axis & !c[cah_pkg::CB_START]) begin
					nxt_r.st = cah_pkg::ST_RELEASE;
					nxt_r.swap_req = 1'b1;
				end
			end
			cah_pkg::ST_SWAP: begin
				nxt_r.cnt = r.cnt + 4'h1;
				if (r.cnt == 4'(cah_pkg::SWAP_CYC - 1)) begin
					nxt_r.swap_req = 1'b0;
					nxt_r.host_axis = 1'b1;
					nxt_r.cnt = 4'h0;
					nxt_r.st = (c[cah_pkg::CB_START] & sf == cah_pkg::EC_NONE) ?
						cah_pkg::ST_MOVE : cah_pkg::ST_IDLE;
				end
			end
			cah_pkg::ST_MOVE: begin
				if (p[cah_pkg::P_FINE] | p[cah_pkg::P_DELDTG]) begin
					nxt_r.reached = 1'b1;
					nxt_r.cancel = p[cah_pkg::P_DELDTG];
					nxt_r.st = cah_pkg::ST_DONE;
				end else if (mf != cah_pkg::EC_NONE) begin
					nxt_r.err = 1'b1;
					nxt_r.code = mf;
					nxt_r.st = cah_pkg::ST_ERR;
				end
			end
			cah_pkg::ST_DONE: begin
				// Host ends the job by dropping start
				if (!c[cah_pkg::CB_START]) begin
					nxt_r.cancel = 1'b1;
					nxt_r.st = cah_pkg::ST_RELEASE;
					nxt_r.swap_req = !c[cah_pkg::CB_REQ];
				end
			end
			cah_pkg::ST_RELEASE: begin
				nxt_r.cnt = r.cnt + 4'h1;
				if (c[cah_pkg::CB_REQ] & !r.swap_req) begin
					nxt_r.reached = 1'b0;
					nxt_r.cnt = 4'h0;
					nxt_r.st = cah_pkg::ST_IDLE;
				end else if (r.cnt == 4'(cah_pkg::SWAP_CYC - 1)) begin
					nxt_r.host_axis = 1'b0;
					nxt_r.swap_req = 1'b0;
					nxt_r.reached = 1'b0;
					nxt_r.cnt = 4'h0;
					nxt_r.st = cah_pkg::ST_IDLE;
				end
			end
			cah_pkg::ST_ERR: begin
				if (!c[cah_pkg::CB_START]) begin
					nxt_r.code = cah_pkg::EC_NONE;
					nxt_r.err = 1'b0;
					nxt_r.cancel = 1'b1;
					nxt_r.swap_req = r.host_axis & !c[cah_pkg::CB_REQ];
					nxt_r.st = r.host_axis ? cah_pkg::ST_RELEASE : cah_pkg::ST_IDLE;
				end
			end
			default: nxt_r.st = cah_pkg::ST_IDLE;
		endcase

		nxt_r.run = (nxt_r.st == cah_pkg::ST_MOVE) & !p[cah_pkg::P_FSTOP]
			& !nxt_r.chan_halt & !nxt_r.ind_halt
			& !(r.imode & c[cah_pkg::CB_IRST]);
		nxt_r.feed_out = (r.feed == 32'h0000_0000) ? POS_VEL : r.feed;
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			r <= '0;
			r.wait_req <= 1'b1;
			r.ctrl <= cah_pkg::CTRL_RESET;
			r.st <= cah_pkg::ST_IDLE;
		end else begin
			r <= nxt_r;
		end
	end

	assign avs_waitrequest = r.wait_req;
	assign avs_readdata = r.rdata;
	assign axis_swap_req = r.swap_req;
	assign move_run = r.run;
	assign move_cancel = r.cancel;
	assign move_incr = r.ctrl[cah_pkg::CB_INCR];
	assign move_inch = r.ctrl[cah_pkg::CB_INCH];
	assign move_target = r.target;
	assign move_feed = r.feed_out;

	property p_no_grab_travel;
		@(posedge ref_clk) disable iff (reset)
		(r.st == cah_pkg::ST_IDLE && travel) |=> r.st != cah_pkg::ST_SWAP;
	endproperty
	a_no_grab_travel: assert property (p_no_grab_travel) else $error("swap while axis travels");

	property p_swap_before_move;
		@(posedge ref_clk) disable iff (reset)
		$rose(r.host_axis) |-> $past(r.swap_req) && $past(r.swap_req, 2);
	endproperty
	a_swap_before_move: assert property (p_swap_before_move) else $error("axis taken w/o swap");

	logic sf_ok;
	assign sf_ok = start_fault(p, c) == cah_pkg::EC_NONE;
	property p_skip_swap;
		@(posedge ref_clk) disable iff (reset)
		(r.st == cah_pkg::ST_IDLE && r.host_axis && c[cah_pkg::CB_START] && !r.reached
			&& !r.err && sf_ok) |=> r.st == cah_pkg::ST_MOVE;
	endproperty
	a_skip_swap: assert property (p_skip_swap) else $error("held axis did not move at once");

	property p_reached_holds;
		@(posedge ref_clk) disable iff (reset)
		(r.st == cah_pkg::ST_RELEASE && r.reached)
			|=> r.reached || r.st == cah_pkg::ST_IDLE;
	endproperty
	a_reached_holds: assert property (p_reached_holds) else $error("reached dropped early");

	property p_release_axis;
		@(posedge ref_clk) disable iff (reset)
		(r.st == cah_pkg::ST_DONE && !c[cah_pkg::CB_START] && !c[cah_pkg::CB_REQ])
			|-> ##[1:8] !r.host_axis;
	endproperty
	a_release_axis: assert property (p_release_axis) else $error("axis not returned");

	property p_code_clear;
		@(posedge ref_clk) disable iff (reset)
		(r.st == cah_pkg::ST_ERR && !c[cah_pkg::CB_START]) |=> r.code == 8'h00 && !r.err;
	endproperty
	a_code_clear: assert property (p_code_clear) else $error("error code not cleared");

	property p_err_blocks;
		@(posedge ref_clk) disable iff (reset)
		r.err |=> r.st != cah_pkg::ST_MOVE;
	endproperty
	a_err_blocks: assert property (p_err_blocks) else $error("start taken during error");

	property p_feed_stop;
		@(posedge ref_clk) disable iff (reset)
		p[cah_pkg::P_FSTOP] |=> !r.run;
	endproperty
	a_feed_stop: assert property (p_feed_stop) else $error("feed stop ignored");

	property p_prog_blocks;
		@(posedge ref_clk) disable iff (reset)
		(c[cah_pkg::CB_IREQ] && p[cah_pkg::P_PROG] && !r.imode) |=> !r.imode && r.ierr;
	endproperty
	a_prog_blocks: assert property (p_prog_blocks) else $error("independent mode granted");

	property p_zero_feed;
		@(posedge ref_clk) disable iff (reset)
		(r.feed == 32'h0000_0000) |=> r.feed_out == POS_VEL;
	endproperty
	a_zero_feed: assert property (p_zero_feed) else $error("zero feed not replaced");

	c_move_done: cover property (@(posedge ref_clk) disable iff (reset)
		r.st == cah_pkg::ST_DONE ##[1:50] r.st == cah_pkg::ST_IDLE);
	c_err_path: cover property (@(posedge ref_clk) disable iff (reset)
		$rose(r.err) ##[1:50] !r.err);
	c_imode: cover property (@(posedge ref_clk) disable iff (reset) $rose(r.imode));
endmodule

/* tb/cah_axis_model.sv */
`timescale 1ns/1ps
module cah_axis_model (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic reset,
	// Motion command from the block, settle time from the bench
	input wire logic move_run,
	input wire logic move_cancel,
	input wire logic [7:0] settle_cyc,
	// Axis checkback
	output logic in_fine_range
);
	typedef struct packed {
		logic [7:0] cnt;
		logic fine;
	} cah_model_type;
	cah_model_type state_ff;
	cah_model_type nxt_state;
	always_comb begin
		nxt_state = state_ff;
		// Distance shrinks only while motion is permitted, so a stopped axis never arrives
		if (move_run && !state_ff.fine) begin
			nxt_state.cnt = state_ff.cnt + 8'h01;
			if (state_ff.cnt >= settle_cyc) begin
				nxt_state.fine = 1'b1;
			end
		end
		if (move_cancel) begin
			nxt_state = '0;
		end
	end
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state_ff <= '0;
		end else begin
			state_ff <= nxt_state;
		end
	end
	assign in_fine_range = state_ff.fine;
endmodule

/* tb/test_cpu_axis_positioning_handshake.sv */
`timescale 1ns/1ps
module test_cpu_axis_positioning_handshake;
	localparam logic [31:0] VEL = 32'h0000_0ABC;
	logic ref_clk, reset, avs_read, avs_write, avs_waitrequest, fine, swap_seen, cancel_seen;
	logic axis_swap_req, move_run, move_cancel, move_incr, move_inch;
	logic [3:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, move_target, move_feed, rd, tgt;
	logic [cah_pkg::NPIN-1:0] pins, base, one;
	logic [7:0] settle;
	logic [63:0] note;
	logic [63:0] exp_q[$];
	int errors, check_count, seed;
	int blk[3] = '{cah_pkg::P_TRAV_P, cah_pkg::P_TRAV_M, cah_pkg::P_MODE};
	cah_axis_ctrl #(.POS_VEL(VEL)) DUT (
		.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.travel_plus(pins[cah_pkg::P_TRAV_P]), .travel_minus(pins[cah_pkg::P_TRAV_M]),
		.feed_stop(pins[cah_pkg::P_FSTOP]), .chan_stop(pins[cah_pkg::P_CSTOP]),
		.chan_start(pins[cah_pkg::P_CSTART]), .delete_dtg(pins[cah_pkg::P_DELDTG]),
		.in_fine_range(fine), .servo_enable(pins[cah_pkg::P_SERVO]),
		.mode_jog_auto(pins[cah_pkg::P_MODE]), .prog_moving(pins[cah_pkg::P_PROG]),
		.swl_plus(pins[cah_pkg::P_SWL_P]), .swl_minus(pins[cah_pkg::P_SWL_M]),
		.wal_plus(pins[cah_pkg::P_WAL_P]), .wal_minus(pins[cah_pkg::P_WAL_M]),
		.target_missed(pins[cah_pkg::P_MISSED]), .short_impossible(pins[cah_pkg::P_SP_IMP]),
		.absm_impossible(pins[cah_pkg::P_ABSM_IMP]),
		.absp_impossible(pins[cah_pkg::P_ABSP_IMP]),
		.axis_swap_req(axis_swap_req), .move_run(move_run), .move_cancel(move_cancel),
		.move_incr(move_incr), .move_inch(move_inch), .move_target(move_target),
		.move_feed(move_feed)
	);
	cah_axis_model MODEL (
		.ref_clk(ref_clk), .reset(reset), .move_run(move_run), .move_cancel(move_cancel),
		.settle_cyc(settle), .in_fine_range(fine)
	);
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= ~wr;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
			if (n > 40) begin
				errors++;
				complete_run();
			end
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	// Every read leaves a note; the monitor compares it when the answer arrives
	task automatic rdn(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		exp_q.push_back({m, e});
		bus(1'b0, a, 32'h0000_0000);
	endtask
	task automatic ctl(input logic [31:0] d);
		bus(1'b1, cah_pkg::ADR_CTRL, d);
	endtask
	task automatic stat(input logic [31:0] m, input logic [31:0] e);
		rdn(cah_pkg::ADR_STAT, m, e);
	endtask
	task automatic wait_st(input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do begin
			stat(32'h0000_0000, 32'h0000_0000);
			n++;
			if (n > 150) begin
				errors++;
				complete_run();
			end
		end while ((rd & m) !== v);
	endtask
	// Pins pass two synchroniser stages, so give them time before looking
	task automatic pin(input int p);
		pins <= (p < 0) ? base : base ^ (one << p);
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic fault(input int pre, input int dur, input logic [31:0] c,
		input logic [31:0] pls, input logic [7:0] code);
		pin(pre);
		ctl(c);
		if (dur >= 0 || pls != 32'h0000_0000) begin
			wait_st(32'h0000_0004, 32'h0000_0004);
			pin(dur);
			if (pls != 32'h0000_0000) begin
				ctl(c | pls);
				ctl(c);
			end
		end
		wait_st(32'h0000_0008, 32'h0000_0008);
		stat(32'h0000_FF00, {16'h0000, code, 8'h00});
		ctl(32'h0000_0000);
		pin(-1);
		wait_st(32'h0000_0008, 32'h0000_0000);
		stat(32'h0000_FF08, 32'h0000_0000);
		wait_st(32'h0000_0001, 32'h0000_0000);
	endtask
	always @(posedge ref_clk) begin
		if (axis_swap_req === 1'b1) begin
			swap_seen <= 1'b1;
		end
		if (move_cancel === 1'b1) begin
			cancel_seen <= 1'b1;
		end
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
			note = exp_q.pop_front();
			check(avs_readdata & note[63:32], note[31:0]);
		end
	end
	initial begin
		reset = 1'b1;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		settle = 8'h10;
		swap_seen = 1'b0;
		cancel_seen = 1'b0;
		errors = 0;
		check_count = 0;
		seed = 39;
		one = 1;
		base = '0;
		base[cah_pkg::P_SERVO] = 1'b1;
		base[cah_pkg::P_MODE] = 1'b1;
		pins = base;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		rdn(cah_pkg::ADR_CTRL, 32'h0000_01FF, 32'h0000_0000);
		stat(32'hFFFF_FFFF, 32'h0000_0000);
		rdn(cah_pkg::ADR_FEED, 32'hFFFF_FFFF, 32'h0000_0000);
		bus(1'b1, 4'h1, 32'hFFFF_FFFF);
		rdn(4'h1, 32'hFFFF_FFFF, 32'h0000_0000);
		check(move_feed, VEL);
		$display("test reset done");
		tgt = $random(seed);
		bus(1'b1, cah_pkg::ADR_TARGET, tgt);
		bus(1'b1, cah_pkg::ADR_FEED, 32'h0000_0123);
		swap_seen = 1'b0;
		ctl(32'h0000_000D);
		wait_st(32'h0000_0001, 32'h0000_0001);
		check({31'h0, swap_seen}, 32'h0000_0001);
		wait_st(32'h0000_0002, 32'h0000_0002);
		check({30'h0, move_inch, move_incr}, 32'h0000_0003);
		check(move_target, tgt);
		check(move_feed, 32'h0000_0123);
		rdn(cah_pkg::ADR_TARGET, 32'hFFFF_FFFF, tgt);
		ctl(32'h0000_0000);
		stat(32'h0000_0002, 32'h0000_0002);
		wait_st(32'h0000_0002, 32'h0000_0000);
		stat(32'h0000_0007, 32'h0000_0000);
		$display("test per-move done");
		ctl(32'h0000_0002);
		wait_st(32'h0000_0001, 32'h0000_0001);
		swap_seen = 1'b0;
		ctl(32'h0000_0003);
		wait_st(32'h0000_0002, 32'h0000_0002);
		check({31'h0, swap_seen}, 32'h0000_0000);
		ctl(32'h0000_0002);
		wait_st(32'h0000_0002, 32'h0000_0000);
		stat(32'h0000_0001, 32'h0000_0001);
		ctl(32'h0000_0000);
		wait_st(32'h0000_0001, 32'h0000_0000);
		$display("test continuous done");
		settle <= 8'hFF;
		ctl(32'h0000_0001);
		wait_st(32'h0000_0004, 32'h0000_0004);
		pin(cah_pkg::P_FSTOP);
		stat(32'h0000_0004, 32'h0000_0000);
		check({31'h0, move_run}, 32'h0000_0000);
		pin(-1);
		stat(32'h0000_0004, 32'h0000_0004);
		pin(cah_pkg::P_CSTOP);
		pin(-1);
		stat(32'h0000_0004, 32'h0000_0000);
		pin(cah_pkg::P_CSTART);
		stat(32'h0000_0004, 32'h0000_0004);
		cancel_seen = 1'b0;
		pin(cah_pkg::P_DELDTG);
		wait_st(32'h0000_0006, 32'h0000_0002);
		check({31'h0, cancel_seen}, 32'h0000_0001);
		ctl(32'h0000_0000);
		pin(-1);
		wait_st(32'h0000_0003, 32'h0000_0000);
		$display("test stops done");
		foreach (blk[i]) begin
			pin(blk[i]);
			swap_seen = 1'b0;
			ctl(32'h0000_0001);
			repeat (20) @(posedge ref_clk);
			stat(32'h0000_0005, 32'h0000_0000);
			stat(32'h0000_FF08, {16'h0000, cah_pkg::EC_NOSTART, 8'h08});
			check({31'h0, swap_seen}, 32'h0000_0000);
			ctl(32'h0000_0000);
			pin(-1);
			wait_st(32'h0000_000B, 32'h0000_0000);
		end
		$display("test refusal done");
		fault(cah_pkg::P_SERVO, -1, 32'h1, 32'h0, cah_pkg::EC_SERVO);
		fault(-1, -1, 32'h15, 32'h0, cah_pkg::EC_SP_INCR);
		fault(cah_pkg::P_SP_IMP, -1, 32'h1, 32'h0, cah_pkg::EC_SP_IMP);
		fault(cah_pkg::P_ABSM_IMP, -1, 32'h1, 32'h0, cah_pkg::EC_ABSM);
		fault(cah_pkg::P_ABSP_IMP, -1, 32'h1, 32'h0, cah_pkg::EC_ABSP);
		fault(-1, cah_pkg::P_SWL_P, 32'h1, 32'h0, cah_pkg::EC_SWL_P);
		fault(-1, cah_pkg::P_SWL_M, 32'h1, 32'h0, cah_pkg::EC_SWL_M);
		fault(-1, cah_pkg::P_WAL_P, 32'h1, 32'h0, cah_pkg::EC_WAL_P);
		fault(-1, cah_pkg::P_WAL_M, 32'h1, 32'h0, cah_pkg::EC_WAL_M);
		fault(-1, cah_pkg::P_MISSED, 32'h1, 32'h0, cah_pkg::EC_MISSED);
		fault(-1, -1, 32'h1, 32'h20, cah_pkg::EC_ABORTED);
		$display("test errors done");
		pin(cah_pkg::P_PROG);
		ctl(32'h0000_0020);
		repeat (10) @(posedge ref_clk);
		stat(32'hFFFF_0010, {cah_pkg::IEC_PROG, 16'h0000});
		ctl(32'h0000_0000);
		pin(-1);
		ctl(32'h0000_0020);
		wait_st(32'h0000_0010, 32'h0000_0010);
		ctl(32'h0000_0021);
		wait_st(32'h0000_0004, 32'h0000_0004);
		ctl(32'h0000_0061);
		wait_st(32'h0000_0004, 32'h0000_0000);
		ctl(32'h0000_00A1);
		wait_st(32'h0000_0004, 32'h0000_0004);
		pin(cah_pkg::P_CSTOP);
		stat(32'h0000_0004, 32'h0000_0004);
		ctl(32'h0000_0121);
		wait_st(32'h0000_0040, 32'h0000_0040);
		ctl(32'h0000_0000);
		pin(-1);
		wait_st(32'h0000_0009, 32'h0000_0000);
		$display("test independent done");
		complete_run();
	end
endmodule
